// ===== rtl/ssmr_device.sv
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
// Function
// - Register read allowed mid memory write
// - Host sends read instruction first
// - Register data follows instruction, no dummies
// - Chip select high stops device drive
// - Host sends write instruction, then byte
// - Host ends write by raising select
// - Bit 0 disables pause; resets enabled
// - Bits 7:6 mode; resets to burst
// - Standby until chip select low
// - Everything shifted most significant first
// - Sample rising, change output falling
// - Pause ignored in quad width
// - Bus width sticks until reset command
module ssmr_device
    import ssmr_pkg::*;
(
    input  wire logic       ref_clk,   // System clock
    input  wire logic       rst,       // Async reset, power-up model
    ssmr_if.device          link,      // Serial pins
    output logic [7:0]      modeReg,   // operating_mode_control contents
    output logic            pauseActive, // Transfer currently paused
    output logic [1:0]      busWidth   // Current line width
);
    import ssmr_pkg::*;

    // **********************************************
    // Pin synchronisers (three stages, data two)
    // **********************************************
    logic [2:0] csSync_q;   // Chip select stages
    logic [2:0] clkSync_q;  // Serial clock stages
    logic [2:0] pauseSync_q;
    logic [3:0] io1_q;      // Data first stage
    logic [3:0] io2_q;      // Data second stage
    logic       csLow_q;    // Filtered select level
    logic       clkHigh_q;  // Filtered clock level
    logic       pauseLow_q; // Filtered pause level

    // Sample all pins; only later stages are ever examined
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            csSync_q    <= 3'h7;
            clkSync_q   <= 3'h0;
            pauseSync_q <= 3'h7;
            io1_q       <= 4'hf;
            io2_q       <= 4'hf;
        end
        else
        begin
            csSync_q    <= {csSync_q[1:0], link.chipSelN};
            clkSync_q   <= {clkSync_q[1:0], link.serClk};
            pauseSync_q <= {pauseSync_q[1:0], link.pauseN};
            io1_q       <= link.ioLine;
            io2_q       <= io1_q;
        end
    end

    // Filtered levels change only when stages two and three agree
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            csLow_q    <= 1'b0;
            clkHigh_q  <= 1'b0;
            pauseLow_q <= 1'b0;
        end
        else
        begin
            if (csSync_q[1] == csSync_q[2])
                csLow_q <= ~csSync_q[2];
            if (clkSync_q[1] == clkSync_q[2])
                clkHigh_q <= clkSync_q[2];
            if (pauseSync_q[1] == pauseSync_q[2])
                pauseLow_q <= ~pauseSync_q[2];
        end
    end

    // Edge detection on filtered levels
    logic clkHighDly_q; // Previous clock level
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            clkHighDly_q <= 1'b0;
        else
            clkHighDly_q <= clkHigh_q;
    end

    // Pause honoured only when enabled and not quad
    logic pauseEff;
    assign pauseEff = pauseLow_q && !modeReg[PAUSE_OFF_BIT] && (busWidth != WIDTH_QUAD);
    wire riseEdge = clkHigh_q && !clkHighDly_q && csLow_q && !pauseEff;
    wire fallEdge = !clkHigh_q && clkHighDly_q && csLow_q && !pauseEff;

    // Input data is aligned to filtered clock by using stage two data
    // Trade-off: data stage is two deep, clock path three; host holds data long
    function automatic logic [7:0] shiftIn(input logic [7:0] cur,
                                           input logic [1:0] w,
                                           input logic [3:0] io);
        case (w)
            WIDTH_DUAL: shiftIn = {cur[5:0], io[1:0]};
            WIDTH_QUAD: shiftIn = {cur[3:0], io[3:0]};
            default:    shiftIn = {cur[6:0], io[0]};
        endcase
    endfunction

    // Bits carried per serial clock
    function automatic logic [3:0] bitsPerClk(input logic [1:0] w);
        case (w)
            WIDTH_DUAL: bitsPerClk = 4'h2;
            WIDTH_QUAD: bitsPerClk = 4'h4;
            default:    bitsPerClk = 4'h1;
        endcase
    endfunction

    // **********************************************
    // Command state machine
    // **********************************************
    typedef enum {
        ST_IDLE,      // Standby or waiting for instruction
        ST_READ_REG,  // Driving register out
        ST_WRITE_REG, // Receiving mode byte
        ST_IGNORE     // Done or unsupported, wait for select high
    } ssmr_state_t;

    ssmr_state_t state_q;   // Command phase
    logic [7:0]  shift_q;   // Incoming bits
    logic [3:0]  bitCnt_q;  // Bits received of current byte
    logic [7:0]  outSh_q;   // Outgoing bits
    logic [3:0]  outCnt_q;  // Bits already presented
    wire  [7:0]  nextByte = shiftIn(shift_q, busWidth, io2_q);
    wire  [3:0]  nextCnt  = bitCnt_q + bitsPerClk(busWidth);

    // Decode instruction, receive mode byte, track state
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q  <= ST_IDLE;
            shift_q  <= 8'h00;
            bitCnt_q <= 4'h0;
            modeReg  <= MODE_REG_RESET;
            busWidth <= WIDTH_SINGLE;
        end
        else if (!csLow_q)
        begin
            // Select high ends every command
            state_q  <= ST_IDLE;
            bitCnt_q <= 4'h0;
        end
        else if (riseEdge)
        begin
            shift_q  <= nextByte;
            bitCnt_q <= (nextCnt == 4'h8) ? 4'h0 : nextCnt;
            case (state_q)
                ST_IDLE:
                begin
                    if (nextCnt == 4'h8)
                    begin
                        case (nextByte)
                            CMD_READ_MODE_REG:  state_q <= ST_READ_REG;
                            CMD_WRITE_MODE_REG: state_q <= ST_WRITE_REG;
                            CMD_ENTER_DUAL:
                            begin
                                busWidth <= WIDTH_DUAL;
                                state_q  <= ST_IGNORE;
                            end
                            CMD_ENTER_QUAD:
                            begin
                                busWidth <= WIDTH_QUAD;
                                state_q  <= ST_IGNORE;
                            end
                            CMD_RESET_SINGLE:
                            begin
                                busWidth <= WIDTH_SINGLE;
                                state_q  <= ST_IGNORE;
                            end
                            default:            state_q <= ST_IGNORE;
                        endcase
                    end
                end
                ST_WRITE_REG:
                begin
                    if (nextCnt == 4'h8)
                    begin
                        modeReg <= nextByte;
                        state_q <= ST_IGNORE;
                    end
                end
                // Read and ignore phases take no input
                default: state_q <= state_q;
            endcase
        end
    end

    // **********************************************
    // Output driver, changes after falling edge
    // **********************************************
    logic [3:0] ioOut_q; // Pin drive
    logic [3:0] ioOe_q;  // Pin enables

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            outSh_q  <= 8'h00;
            outCnt_q <= 4'h0;
            ioOut_q  <= 4'h0;
            ioOe_q   <= 4'h0;
        end
        else if (!csLow_q || state_q != ST_READ_REG)
        begin
            // Release lines the cycle after the filtered select goes high
            outSh_q  <= modeReg;
            outCnt_q <= 4'h0;
            ioOe_q   <= 4'h0;
        end
        else if (fallEdge)
        begin
            // Register repeats while the host keeps clocking
            case (busWidth)
                WIDTH_DUAL:
                begin
                    ioOut_q <= {2'h0, outSh_q[7:6]};
                    ioOe_q  <= 4'h3;
                    outSh_q <= (outCnt_q == 4'h6) ? modeReg : {outSh_q[5:0], 2'h0};
                end
                WIDTH_QUAD:
                begin
                    ioOut_q <= outSh_q[7:4];
                    ioOe_q  <= 4'hf;
                    outSh_q <= (outCnt_q == 4'h4) ? modeReg : {outSh_q[3:0], 4'h0};
                end
                default:
                begin
                    // Single line: data out on line 1
                    ioOut_q <= {2'h0, outSh_q[7], 1'b0};
                    ioOe_q  <= 4'h2;
                    outSh_q <= (outCnt_q == 4'h7) ? modeReg : {outSh_q[6:0], 1'b0};
                end
            endcase
            outCnt_q <= (outCnt_q + bitsPerClk(busWidth) == 4'h8) ? 4'h0 :
                        outCnt_q + bitsPerClk(busWidth);
        end
    end

    // Paused state reported for observers
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            pauseActive <= 1'b0;
        else
            pauseActive <= pauseEff && csLow_q;
    end

    assign link.devIoOut = ioOut_q;
    assign link.devIoOe  = ioOe_q;
endmodule

// ===== rtl/ssmr_pkg.sv
package ssmr_pkg;
    // **********************************************
    // Instruction codes
    // **********************************************
    localparam logic [7:0] CMD_READ_MODE_REG  = 8'h05; // read_mode_reg_cmd
    localparam logic [7:0] CMD_WRITE_MODE_REG = 8'h01; // write_mode_reg_cmd
    localparam logic [7:0] CMD_ENTER_QUAD     = 8'h38; // Widen to four lines
    localparam logic [7:0] CMD_ENTER_DUAL     = 8'h3b; // Widen to two lines
    localparam logic [7:0] CMD_RESET_SINGLE   = 8'hff; // Back to one line

    // **********************************************
    // Register layout
    // **********************************************
    localparam int         PAUSE_OFF_BIT  = 0;        // Pause disable bit
    localparam int         OPMODE_LSB     = 6;        // Operating mode field
    localparam int         OPMODE_MSB     = 7;
    localparam logic [7:0] MODE_REG_RESET = 8'h40;    // Burst, pause enabled
    localparam logic [1:0] OPMODE_WORD    = 2'h0;
    localparam logic [1:0] OPMODE_PAGE    = 2'h2;
    localparam logic [1:0] OPMODE_BURST   = 2'h1;

    // **********************************************
    // Bus widths
    // **********************************************
    localparam logic [1:0] WIDTH_SINGLE = 2'h0;
    localparam logic [1:0] WIDTH_DUAL   = 2'h1;
    localparam logic [1:0] WIDTH_QUAD   = 2'h2;

    // **********************************************
    // Host register map (APB, byte addresses)
    // **********************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00; // [0] go, [1] write, [3:2] width
    localparam logic [7:0] ADDR_WDATA  = 8'h04; // Mode byte to write
    localparam logic [7:0] ADDR_STATUS = 8'h08; // [0] busy, [15:8] last read byte
    localparam int         CTRL_GO_BIT = 0;
    localparam int         CTRL_WR_BIT = 1;
    localparam int         SCK_HALF    = 8;     // Ref clocks per half serial clock; covers the
                                                // device's synchroniser delay within one phase
endpackage

// ===== rtl/ssmr_if.sv
`timescale 1ns/1ps
// Serial link between host and memory device
interface ssmr_if;
    logic       chipSelN;   // Chip select, active low
    logic       serClk;     // Serial clock from host
    logic       pauseN;     // Pause input, active low
    logic [3:0] hostIoOut;  // Host drive on multiplexed_io_lines
    logic [3:0] hostIoOe;   // Host enables
    logic [3:0] devIoOut;   // Device drive
    logic [3:0] devIoOe;    // Device enables
    logic [3:0] ioLine;     // Resolved wire level
    // Resolve lines: device wins where it drives, else host, else pulled up
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            ioLine[i] = devIoOe[i] ? devIoOut[i] : (hostIoOe[i] ? hostIoOut[i] : 1'b1);
        end
    end
    modport device (input chipSelN, input serClk, input pauseN, input ioLine,
                    output devIoOut, output devIoOe);
    modport host   (output chipSelN, output serClk, output pauseN, input ioLine,
                    output hostIoOut, output hostIoOe);
endinterface

// ===== rtl/ssmr_host.sv
`timescale 1ns/1ps
// Host controller: APB commands, serial mode register access
module ssmr_host
    import ssmr_pkg::*;
(
    input  wire logic        ref_clk,  // System clock
    input  wire logic        rst,      // Async reset
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB enable
    input  wire logic        pwrite,   // APB direction
    input  wire logic [7:0]  paddr,    // APB byte address
    input  wire logic [31:0] pwdata,   // APB write data
    output logic      [31:0] prdata,   // APB read data
    output logic             pready,   // APB ready
    output logic             pslverr,  // APB error
    ssmr_if.host             link      // Serial pins
);
    import ssmr_pkg::*;

    // **********************************************
    // Registers
    // **********************************************
    logic       wr_q;      // Pending op is write
    logic [1:0] width_q;   // Width assumed on the link
    logic [7:0] wdata_q;   // Byte to write
    logic [7:0] rdata_q;   // Byte read back
    logic       busy_q;    // Transfer running
    logic       go;        // Start pulse from APB

    wire access = psel && penable;
    assign go = access && pwrite && paddr == ADDR_CTRL && pwdata[CTRL_GO_BIT] && !busy_q;
    // Direction comes from the very write that starts the frame
    wire [7:0] goCmd = pwdata[CTRL_WR_BIT] ? CMD_WRITE_MODE_REG : CMD_READ_MODE_REG;

    // APB answers in the access cycle, zero wait states
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            wr_q    <= 1'b0;
            width_q <= WIDTH_SINGLE;
            wdata_q <= 8'h00;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == ADDR_CTRL ||
                       paddr == ADDR_WDATA || paddr == ADDR_STATUS);
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    ADDR_CTRL:   prdata <= {28'h0, width_q, wr_q, 1'b0};
                    ADDR_WDATA:  prdata <= {24'h0, wdata_q};
                    ADDR_STATUS: prdata <= {16'h0, rdata_q, 7'h0, busy_q};
                    default:     prdata <= 32'h0;
                endcase
            end
            if (access && pwrite && !busy_q)
            begin
                if (paddr == ADDR_CTRL)
                begin
                    wr_q    <= pwdata[CTRL_WR_BIT];
                    width_q <= pwdata[3:2];
                end
                if (paddr == ADDR_WDATA)
                    wdata_q <= pwdata[7:0];
            end
        end
    end

    // **********************************************
    // Serial engine: 16 bits, instruction then byte
    // **********************************************
    logic [2:0]  div_q;   // Half-period counter
    logic [4:0]  bit_q;   // Bit positions sent
    logic        sck_q;   // Serial clock
    logic        csN_q;   // Select
    logic [15:0] tx_q;    // Outgoing bits
    logic [3:0]  oe_q;    // Line enables
    logic [3:0]  out_q;   // Line drive
    logic [3:0]  rdS1_q;  // Read line synchroniser stages
    logic [3:0]  rdS2_q;
    logic [3:0]  rdS3_q;
    wire  [4:0]  step = (width_q == WIDTH_QUAD) ? 5'h4 :
                        (width_q == WIDTH_DUAL) ? 5'h2 : 5'h1;
    wire  [4:0]  bitNext = bit_q + step;
    wire  [15:0] txNext  = (width_q == WIDTH_QUAD) ? {tx_q[11:0], rdS3_q} :
                           (width_q == WIDTH_DUAL) ? {tx_q[13:0], rdS3_q[1:0]} :
                                                     {tx_q[14:0], rdS3_q[1]};

    // Lines the host drives for a width
    function automatic logic [3:0] lineEn(input logic [1:0] w);
        case (w)
            WIDTH_QUAD: lineEn = 4'hf;
            WIDTH_DUAL: lineEn = 4'h3;
            default:    lineEn = 4'h1;
        endcase
    endfunction

    // Leading bits shown on those lines, MSB first
    function automatic logic [3:0] lineBits(input logic [1:0] w, input logic [15:0] t);
        case (w)
            WIDTH_QUAD: lineBits = t[15:12];
            WIDTH_DUAL: lineBits = {2'h3, t[15:14]};
            default:    lineBits = {3'h7, t[15]};
        endcase
    endfunction

    // Device answer is late by its own synchroniser, so it is taken at the fall
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rdS1_q <= 4'hf;
            rdS2_q <= 4'hf;
            rdS3_q <= 4'hf;
        end
        else
        begin
            rdS1_q <= link.ioLine;
            rdS2_q <= rdS1_q;
            rdS3_q <= rdS2_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            div_q   <= 3'h0;
            bit_q   <= 5'h0;
            sck_q   <= 1'b0;
            csN_q   <= 1'b1;
            busy_q  <= 1'b0;
            tx_q    <= 16'h0;
            oe_q    <= 4'h0;
            out_q   <= 4'hf;
            rdata_q <= 8'h00;
        end
        else if (go)
        begin
            busy_q <= 1'b1;
            csN_q  <= 1'b0;
            tx_q   <= {goCmd, wdata_q};
            out_q  <= lineBits(pwdata[3:2], {goCmd, wdata_q});
            oe_q   <= lineEn(pwdata[3:2]);
            bit_q  <= 5'h0;
            div_q  <= 3'h0;
        end
        else if (busy_q)
        begin
            div_q <= (div_q == 3'(SCK_HALF - 1)) ? 3'h0 : div_q + 3'h1;
            if (div_q == 3'(SCK_HALF - 1))
            begin
                if (bit_q == 5'h10)
                begin
                    csN_q  <= 1'b1;
                    busy_q <= 1'b0;
                    oe_q   <= 4'h0;
                    if (!wr_q)
                        rdata_q <= tx_q[7:0];
                end
                else if (!sck_q)
                begin
                    // Rise: host bits have stood the whole low phase
                    sck_q <= 1'b1;
                end
                else
                begin
                    // Fall: take device bits, then show the next host bits
                    sck_q <= 1'b0;
                    bit_q <= bitNext;
                    tx_q  <= txNext;
                    out_q <= lineBits(width_q, txNext);
                    oe_q  <= ((bitNext < 5'h8 || wr_q) && bitNext < 5'h10) ?
                             lineEn(width_q) : 4'h0;
                end
            end
        end
    end

    assign link.chipSelN = csN_q;
    assign link.serClk   = sck_q;
    assign link.pauseN   = 1'b1;
    assign link.hostIoOut = out_q;
    assign link.hostIoOe  = oe_q;
endmodule

// ===== testbench/ssmr_props.sv
`timescale 1ns/1ps
// ****************************************
// Link checker: watches both ends on the wire
// ****************************************
module ssmr_props
    import ssmr_pkg::*;
(
    input wire logic       ref_clk,   // System clock
    input wire logic       rst,       // Async reset
    input wire logic       chipSelN,  // Select, active low
    input wire logic       serClk,    // Serial clock
    input wire logic [3:0] hostIoOut, // Host drive
    input wire logic [3:0] hostIoOe,  // Host enables
    input wire logic [3:0] devIoOut,  // Device drive
    input wire logic [3:0] devIoOe,   // Device enables
    input wire logic [3:0] ioLine     // Resolved lines
);
    logic [4:0] bitCnt; // Rising serial edges in this frame
    logic [7:0] cmdQ;   // Instruction seen on line 0
    logic       sckQ;   // Serial clock one cycle late

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Edge counter; raised select clears it, so a frame never leaks into the next
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            bitCnt <= 5'h0;
        else if (chipSelN)
            bitCnt <= 5'h0;
        else if (serClk && !sckQ && bitCnt != 5'h1f)
            bitCnt <= bitCnt + 5'h1;
    end

    // Instruction capture, first eight bits only
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cmdQ <= 8'h0;
        else if (!chipSelN && serClk && !sckQ && bitCnt < 5'h8)
            cmdQ <= {cmdQ[6:0], ioLine[0]};
    end

    // Delayed serial clock for edge finding
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            sckQ <= 1'b0;
        else
            sckQ <= serClk;
    end

    // ****************************************
    // Sequences
    // ****************************************
    sequence sckHighPhase;
        serClk [*8] ##1 !serClk;
    endsequence
    sequence devStarts;
        ##4 !devIoOe[1] ##1 devIoOe[1];
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    idle_no_drive_a: assert property (chipSelN [*6] |-> devIoOe == 4'h0)
        else $error("device drives while deselected");
    drive_release_a: assert property ($rose(chipSelN) |-> ##5 devIoOe == 4'h0)
        else $error("device kept driving after select rose");
    out_on_low_a: assert property ((devIoOe != 4'h0 && $changed(devIoOut)) |-> !serClk)
        else $error("device output changed while serial clock high");
    host_hold_a: assert property ((serClk && !chipSelN) |-> $stable(hostIoOut))
        else $error("host data moved while serial clock high");
    clk_idle_a: assert property (chipSelN [*2] |-> !serClk)
        else $error("serial clock toggles outside a frame");
    sck_phase_a: assert property ($rose(serClk) |-> sckHighPhase)
        else $error("serial clock high phase wrong length");
    frame_len_a: assert property ($rose(chipSelN) |-> bitCnt == 5'h10)
        else $error("frame not sixteen serial clocks");
    no_dummy_a: assert property (($fell(serClk) && bitCnt == 5'h8
        && cmdQ == CMD_READ_MODE_REG) |-> devStarts)
        else $error("register data late after read instruction");
    single_lines_a: assert property (((devIoOe & 4'hd) | (hostIoOe & 4'he)) == 4'h0)
        else $error("line used outside single width");
    write_quiet_a: assert property ((bitCnt >= 5'h8 && cmdQ == CMD_WRITE_MODE_REG)
        |-> devIoOe == 4'h0)
        else $error("device drives during register write");
endmodule

// ===== testbench/ssmr_tb.sv
`timescale 1ns/1ps
// ****************************************
// Bench: host and device back to back
// ****************************************
module ssmr_tb;
    import ssmr_pkg::*;
    logic        ref_clk;     // 50 MHz
    logic        rst;         // Async reset
    logic        psel;        // APB master side
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  modeReg;     // Device register
    logic        pauseActive;
    logic [1:0]  busWidth;
    logic [15:0] mosiQ;       // Line 0 bits of last frame
    logic [15:0] misoQ;       // Line 1 bits of last frame
    logic        sckQ;
    logic [31:0] rd;          // Last APB read data
    logic        err;         // Last APB error flag
    int          error_cnt;
    int          compares;
    // Rows: byte written (high) beside register expected (low)
    logic [15:0] rows [4] = '{16'h0000, 16'h8080, 16'h4141, 16'h0101};

    ssmr_if link();
    ssmr_host ssmr_host_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    ssmr_device ssmr_device_i (.ref_clk(ref_clk), .rst(rst), .link(link), .modeReg(modeReg),
        .pauseActive(pauseActive), .busWidth(busWidth));
    ssmr_props ssmr_props_i (.ref_clk(ref_clk), .rst(rst), .chipSelN(link.chipSelN),
        .serClk(link.serClk), .hostIoOut(link.hostIoOut), .hostIoOe(link.hostIoOe),
        .devIoOut(link.devIoOut), .devIoOe(link.devIoOe), .ioLine(link.ioLine));

    // Clock
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Wire monitor: shifts both lines at each rising serial edge in a frame
    always @(posedge ref_clk)
    begin
        if (!link.chipSelN && link.serClk && !sckQ)
        begin
            mosiQ <= {mosiQ[14:0], link.ioLine[0]};
            misoQ <= {misoQ[14:0], link.ioLine[1]};
        end
        sckQ <= link.serClk;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready, no fixed latency assumed
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Poll busy until clear, bounded
    task wait_idle();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end
        while (rd[0] !== 1'b0 && n < 1000);
        chk({31'h0, rd[0]}, 32'h0);
    endtask

    // Single-width register command: write when wr set, else read
    task run(input logic wr, input logic [7:0] v);
        apb(1'b1, ADDR_WDATA, {24'h0, v});
        apb(1'b1, ADDR_CTRL, wr ? 32'h3 : 32'h1);
        wait_idle();
    endtask

    task final_report();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog, well beyond the few thousand cycles the tests need
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        final_report();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        error_cnt = 0;
        compares = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk({24'h0, modeReg}, {24'h0, MODE_REG_RESET});
        chk({30'h0, busWidth}, {30'h0, WIDTH_SINGLE});
        chk({31'h0, link.chipSelN}, 32'h1);
        chk({31'h0, pauseActive}, 32'h0);
        // Table: write, then read back over the wire
        foreach (rows[i])
        begin
            run(1'b1, rows[i][15:8]);
            chk({24'h0, modeReg}, {24'h0, rows[i][7:0]});
            chk({16'h0, mosiQ}, {16'h0, CMD_WRITE_MODE_REG, rows[i][15:8]});
            run(1'b0, 8'h0);
            chk({24'h0, rd[15:8]}, {24'h0, rows[i][7:0]});
            chk({24'h0, misoQ[7:0]}, {24'h0, rows[i][7:0]});
            chk({24'h0, mosiQ[15:8]}, {24'h0, CMD_READ_MODE_REG});
        end
        // Unmapped address, both directions
        apb(1'b0, 8'h0c, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h0c, 32'hff);
        chk({31'h0, err}, 32'h1);
        // Writes while busy must not disturb the frame in flight
        apb(1'b1, ADDR_WDATA, 32'h81);
        apb(1'b1, ADDR_CTRL, 32'h3);
        apb(1'b1, ADDR_WDATA, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h3);
        wait_idle();
        chk({24'h0, modeReg}, 32'h81);
        // Second reset in mid-run
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk({24'h0, modeReg}, {24'h0, MODE_REG_RESET});
        run(1'b0, 8'h0);
        chk({24'h0, rd[15:8]}, {24'h0, MODE_REG_RESET});
        final_report();
    end
endmodule
